// ---- rtl/udp_uart.sv ----
// serial port: fifo and the transmit / receive engine
// =========================================================
// udp_fifo: parameterised first-in first-out buffer
module udp_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // storage
    logic [AW:0] cnt;         // words held
    logic [AW-1:0] wp;        // write pointer
    logic [AW-1:0] rp;        // read pointer
  } udp_fifo_t;
  udp_fifo_t q, d;
  logic push, pop;
  // flags come from the count, so full and empty are exact
  assign inReady = (q.cnt != (AW+1)'(D));
  assign outValid = (q.cnt != '0);
  assign outData = q.mem[q.rp];
  // next state
  always_comb begin
    d = q;
    push = inValid & inReady;
    pop = outValid & outReady;
    if (push) begin
      d.mem[q.wp] = inData;
      d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
    end
    // simultaneous push and pop leaves the count alone
    if (push & ~pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop & ~push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end
  // state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // udp_fifo

// =========================================================
// udp_uart: full-duplex asynchronous serial port
// Overview of operation
// - separate transmit and receive engines run concurrently
// - conventional start, data, parity, stop framing
// - nine-bit mode carries an address flag bit
// - five to eight data, one or two stops
// - parity none, even or odd, generated and checked
// - frame spans seven to twelve bit periods
// - programmed mode: write holding, read buffer
// - holding register before the transmit shift register, buffer after the receive one
// - dma mode uses a transmit and receive channel
// - dma channels default to low priority
// - bit rate from clock/1048576 to clock/16
// - receive errors latched, reporting gated
// - transmit and receive interrupts individually maskable
// - synced receive level exported for baud timer
module udp_uart
  import udp_pkg::*;
#(
  parameter int DIV_W = UDP_DIV_W,
  parameter int DEPTH = UDP_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic rxdPin,
  output logic txdPin,
  input wire logic [DIV_W-1:0] baudDiv,
  input wire logic [1:0] dataBits,
  input wire logic twoStop,
  input wire logic [1:0] parityMode,
  input wire logic addrMode,
  input wire logic dmaMode,
  input wire logic dmaPrioRaise,
  input wire logic txIrqEn,
  input wire logic rxIrqEn,
  input wire logic errIrqEn,
  input wire logic errClear,
  input wire logic txWrite,
  input wire logic [8:0] txData,
  output logic txReady,
  input wire logic rxRead,
  output logic [8:0] rxData,
  output logic rxValid,
  output logic txDmaReq,
  input wire logic txDmaAck,
  input wire logic [8:0] txDmaData,
  output logic rxDmaReq,
  input wire logic rxDmaAck,
  output logic [1:0] dmaPrio,
  output logic parityErr,
  output logic frameErr,
  output logic overrunErr,
  output logic txIrq,
  output logic rxIrq,
  output logic rxLevel
);
  // =========================================================
  // state of the port
  typedef struct packed {
    logic rxMeta;              // synchroniser first stage
    logic rxSync;              // synchroniser second stage
    logic [DIV_W-1:0] baudCnt; // tick divider
    udp_tx_t txSt;             // transmit engine
    logic [3:0] txSub;         // tick within bit
    logic [3:0] txCnt;         // bit counter
    logic [8:0] txShift;       // transmit shifter
    logic txPar;               // parity bit to send
    logic txLine;              // serial output
    logic [8:0] txHold;        // transmit holding word
    logic txHoldFull;          // holding word present
    logic txRdy;               // holding word empty, registered for the pin
    udp_rx_t rxSt;             // receive engine
    logic [3:0] rxSub;         // tick within bit
    logic [3:0] rxCnt;         // bit counter
    logic [8:0] rxShift;       // receive shifter
    logic [8:0] rxWord;        // justified character
    logic rxParBit;            // sampled parity bit
    logic rxPush;              // one-cycle write into fifo
    logic [8:0] rxOut;         // receive buffer word
    logic rxOutValid;          // receive buffer present
    logic parErr;              // sticky parity error
    logic frmErr;              // sticky framing error
    logic ovrErr;              // sticky overrun
    logic txIrq;
    logic rxIrq;
    logic txDmaReq;
    logic rxDmaReq;
    logic [1:0] dmaPrio;
  } udp_state_t;
  udp_state_t q, d;

  logic tick;           // one sixteenth of a bit
  logic [3:0] nBits;    // bits per character
  logic [8:0] mask;     // valid data bits
  logic parOn;          // parity bit in frame
  logic oddPar;         // odd parity selected
  logic txLoad;         // request to queue a character
  logic [8:0] txIn;     // character being queued
  logic rxPop;          // receive buffer consumed
  logic [8:0] shNext;   // receive shifter after sample
  logic fifoInReady;
  logic fifoOutValid;
  logic [8:0] fifoOutData;
  logic fifoOutReady;

  // =========================================================
  // receive buffer between the shifter and the read buffer
  // eight words of slack let dma service late without loss
  udp_fifo #(
    .W(UDP_WORD_W),
    .D(DEPTH)
  ) u_rxFifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inValid(q.rxPush),
    .inData(q.rxWord),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoOutReady)
  );

  // buffer refills whenever it is empty or being read
  assign fifoOutReady = ~q.rxOutValid | rxPop;

  // =========================================================
  // next-state logic
  always_comb begin
    d = q;
    shNext = '0;
    // character format
    nBits = addrMode ? UDP_ADDR_BITS : UDP_DBITS_BASE + {2'h0, dataBits};
    mask = UDP_MASK_FULL >> (UDP_ADDR_BITS - nBits);
    parOn = ~addrMode & (parityMode != UDP_PAR_NONE);
    oddPar = (parityMode == UDP_PAR_ODD);
    // pin is asynchronous: two stages before use
    d.rxMeta = rxdPin;
    d.rxSync = q.rxMeta;
    // divisor zero means 65536, giving the slowest rate
    tick = (q.baudCnt == '0);
    d.baudCnt = tick ? baudDiv - 1'b1 : q.baudCnt - 1'b1;
    // source of characters depends on transfer mode
    txLoad = dmaMode ? txDmaAck : txWrite;
    txIn = dmaMode ? txDmaData : txData;
    rxPop = q.rxOutValid & (dmaMode ? rxDmaAck : rxRead);
    d.rxPush = 1'b0;

    // -------- transmit engine
    case (q.txSt)
      TX_IDLE: begin
        d.txLine = 1'b1;
        if (q.txHoldFull) begin
          // move holding word into the shifter
          d.txShift = q.txHold & mask;
          d.txPar = (^(q.txHold & mask)) ^ oddPar;
          d.txHoldFull = 1'b0;
          d.txLine = 1'b0;
          d.txSub = '0;
          d.txSt = TX_START;
        end
      end
      TX_START: begin
        if (tick) begin
          d.txSub = q.txSub + 1'b1;
          if (q.txSub == UDP_SUB_LAST) begin
            d.txLine = q.txShift[0];
            d.txCnt = '0;
            d.txSt = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          d.txSub = q.txSub + 1'b1;
          if (q.txSub == UDP_SUB_LAST) begin
            if (q.txCnt == nBits - 1'b1) begin
              d.txCnt = '0;
              if (parOn) begin
                d.txLine = q.txPar;
                d.txSt = TX_PAR;
              end else begin
                d.txLine = 1'b1;
                d.txSt = TX_STOP;
              end
            end else begin
              // least significant bit leaves first
              d.txShift = q.txShift >> 1;
              d.txLine = d.txShift[0];
              d.txCnt = q.txCnt + 1'b1;
            end
          end
        end
      end
      TX_PAR: begin
        if (tick) begin
          d.txSub = q.txSub + 1'b1;
          if (q.txSub == UDP_SUB_LAST) begin
            d.txLine = 1'b1;
            d.txCnt = '0;
            d.txSt = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          d.txSub = q.txSub + 1'b1;
          if (q.txSub == UDP_SUB_LAST) begin
            if (twoStop & (q.txCnt == '0)) begin
              d.txCnt = 4'h1;
            end else begin
              d.txSt = TX_IDLE;
            end
          end
        end
      end
      default: begin
        d.txSt = TX_IDLE;
        d.txLine = 1'b1;
      end
    endcase
    // a queued character waits while another shifts
    if (txLoad & ~q.txHoldFull) begin
      d.txHold = txIn;
      d.txHoldFull = 1'b1;
    end

    // -------- errors: clear first, so a same-cycle event below wins
    if (errClear) begin
      d.parErr = 1'b0;
      d.frmErr = 1'b0;
      d.ovrErr = 1'b0;
    end

    // -------- receive engine, independent of transmit
    case (q.rxSt)
      RX_IDLE: begin
        // falling edge on the idle-high line
        if (~q.rxSync) begin
          d.rxSub = '0;
          d.rxSt = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          d.rxSub = q.rxSub + 1'b1;
          if (q.rxSub == UDP_SUB_MID) begin
            // re-centre: later samples fall mid-bit
            d.rxSub = '0;
            d.rxCnt = '0;
            // a glitch shorter than half a bit is ignored
            d.rxSt = q.rxSync ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          d.rxSub = q.rxSub + 1'b1;
          if (q.rxSub == UDP_SUB_LAST) begin
            shNext = {q.rxSync, q.rxShift[8:1]};
            d.rxShift = shNext;
            if (q.rxCnt == nBits - 1'b1) begin
              d.rxWord = shNext >> (UDP_ADDR_BITS - nBits);
              d.rxSt = parOn ? RX_PAR : RX_STOP;
            end else begin
              d.rxCnt = q.rxCnt + 1'b1;
            end
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          d.rxSub = q.rxSub + 1'b1;
          if (q.rxSub == UDP_SUB_LAST) begin
            d.rxParBit = q.rxSync;
            d.rxSt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          d.rxSub = q.rxSub + 1'b1;
          if (q.rxSub == UDP_SUB_LAST) begin
            // only the first stop bit is checked
            if (~q.rxSync) begin
              d.frmErr = 1'b1;
            end
            if (parOn & ((^q.rxWord ^ q.rxParBit) != oddPar)) begin
              d.parErr = 1'b1;
            end
            d.rxPush = 1'b1;
            d.rxSt = RX_IDLE;
          end
        end
      end
      default: begin
        d.rxSt = RX_IDLE;
      end
    endcase

    // character lost when the buffer is full
    if (q.rxPush & ~fifoInReady) begin
      d.ovrErr = 1'b1;
    end

    // -------- receive buffer word
    if (rxPop) begin
      d.rxOutValid = 1'b0;
    end
    if (fifoOutValid & fifoOutReady) begin
      d.rxOut = fifoOutData;
      d.rxOutValid = 1'b1;
    end

    // -------- interrupts and dma requests
    d.txIrq = txIrqEn & ~q.txHoldFull;
    d.rxIrq = rxIrqEn & q.rxOutValid | errIrqEn & (q.parErr | q.frmErr | q.ovrErr);
    d.txDmaReq = dmaMode & ~d.txHoldFull;
    // ready kept as its own flop so the output needs no inverter
    d.txRdy = ~d.txHoldFull;
    d.rxDmaReq = dmaMode & d.rxOutValid;
    d.dmaPrio = dmaPrioRaise ? UDP_DMA_PRIO_HIGH : UDP_DMA_PRIO_LOW;
  end

  // =========================================================
  // state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.rxMeta <= 1'b1;
      q.rxSync <= 1'b1;
      q.txLine <= 1'b1;
      q.txRdy <= 1'b1;
      q.txSt <= TX_IDLE;
      q.rxSt <= RX_IDLE;
      q.dmaPrio <= UDP_DMA_PRIO_LOW;
    end else begin
      q <= d;
    end
  end

  // =========================================================
  // outputs, all taken from the state register
  assign txdPin = q.txLine;
  assign txReady = q.txRdy;
  assign rxData = q.rxOut;
  assign rxValid = q.rxOutValid;
  assign txDmaReq = q.txDmaReq;
  assign rxDmaReq = q.rxDmaReq;
  assign dmaPrio = q.dmaPrio;
  assign parityErr = q.parErr;
  assign frameErr = q.frmErr;
  assign overrunErr = q.ovrErr;
  assign txIrq = q.txIrq;
  assign rxIrq = q.rxIrq;
  // the external timer measures bit widths on this level
  assign rxLevel = q.rxSync;
endmodule // udp_uart

// ---- rtl/udp_pkg.sv ----
// shared constants and types of the serial port block
package udp_pkg;
  // =========================================================
  // widths and depths
  localparam int UDP_WORD_W = 9;     // eight data bits plus address flag
  localparam int UDP_FIFO_DEPTH = 8; // receive buffer words
  localparam int UDP_DIV_W = 16;     // baud divisor width
  // =========================================================
  // bit timing, in sixteenth-of-a-bit ticks
  localparam logic [3:0] UDP_SUB_LAST = 4'hF; // last tick of a bit
  localparam logic [3:0] UDP_SUB_MID = 4'h7;  // centre of the start bit
  // =========================================================
  // character format
  localparam logic [3:0] UDP_DBITS_BASE = 4'h5; // data bits for code 0
  localparam logic [3:0] UDP_ADDR_BITS = 4'h9;  // 9-bit address mode
  localparam logic [8:0] UDP_MASK_FULL = 9'h1FF;
  localparam logic [1:0] UDP_PAR_NONE = 2'h0;
  localparam logic [1:0] UDP_PAR_EVEN = 2'h1;
  localparam logic [1:0] UDP_PAR_ODD = 2'h2;
  // =========================================================
  // dma arbitration level
  localparam logic [1:0] UDP_DMA_PRIO_LOW = 2'h0;
  localparam logic [1:0] UDP_DMA_PRIO_HIGH = 2'h3;
  // =========================================================
  // state machines
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
  } udp_tx_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } udp_rx_t;
endpackage

// ---- tb/udp_uart_monitor.sv ----
// concurrent checks on the serial port's ports, bound into udp_uart
module udp_uart_monitor
  import udp_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] dataBits,
  input wire logic addrMode,
  input wire logic dmaMode,
  input wire logic dmaPrioRaise,
  input wire logic txIrqEn,
  input wire logic rxIrqEn,
  input wire logic errIrqEn,
  input wire logic errClear,
  input wire logic txWrite,
  input wire logic txDmaAck,
  input wire logic rxDmaAck,
  input wire logic txdPin,
  input wire logic txReady,
  input wire logic [8:0] rxData,
  input wire logic rxValid,
  input wire logic txDmaReq,
  input wire logic rxDmaReq,
  input wire logic [1:0] dmaPrio,
  input wire logic parityErr,
  input wire logic frameErr,
  input wire logic overrunErr,
  input wire logic txIrq,
  input wire logic rxIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain, so clock and reset are given once
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // sticky error flags gathered for the hold check
  wire logic [2:0] errs = {parityErr, frameErr, overrunErr};
  // ======================================
  // reset and transmit side
  // reset must not mask itself, hence its own disable
  reset_idle_a: assert property (disable iff (1'b0) sys_rst |=> txdPin && txReady && !rxValid)
    else $error("port not idle after reset");
  write_taken_a: assert property (txWrite && txReady && !dmaMode |=> !txReady)
    else $error("holding register not filled by a write");
  ready_cause_a: assert property ($fell(txReady) |->
    (!$past(dmaMode) && $past(txWrite)) || ($past(dmaMode) && $past(txDmaAck)))
    else $error("holding register filled without a request");
  // ======================================
  // dma and priority
  prio_high_a: assert property (dmaPrioRaise |=> dmaPrio == UDP_DMA_PRIO_HIGH)
    else $error("raised priority not shown");
  prio_low_a: assert property (!dmaPrioRaise |=> dmaPrio == UDP_DMA_PRIO_LOW)
    else $error("default priority not low");
  dma_req_a: assert property (txDmaReq || rxDmaReq |-> $past(dmaMode))
    else $error("dma request outside dma mode");
  // ======================================
  // receive side, errors and interrupts
  err_sticky_a: assert property (errs != 3'h0 && !errClear |=> (errs & $past(errs)) == $past(errs))
    else $error("error flag lost without a clear");
  overrun_full_a: assert property ($rose(overrunErr) |-> $past(rxValid))
    else $error("overrun while read buffer empty");
  rx_justify_a: assert property (rxValid && !addrMode |-> (rxData >> (dataBits + 4'h5)) == 9'h000)
    else $error("received character not right justified");
  tx_mask_a: assert property (!txIrqEn |=> !txIrq)
    else $error("transmit interrupt while masked");
  rx_mask_a: assert property (!rxIrqEn && !errIrqEn |=> !rxIrq)
    else $error("receive interrupt while masked");
  // main scenarios reached
  write_c: cover property (txWrite && txReady);
  overrun_c: cover property ($rose(overrunErr));
  dma_c: cover property (rxDmaReq && rxDmaAck);
endmodule // udp_uart_monitor

bind udp_uart udp_uart_monitor mon (.mclk, .sys_rst, .dataBits, .addrMode, .dmaMode,
  .dmaPrioRaise, .txIrqEn, .rxIrqEn, .errIrqEn, .errClear, .txWrite, .txDmaAck, .txdPin,
  .txReady, .rxData, .rxValid, .txDmaReq, .rxDmaReq, .dmaPrio, .parityErr, .frameErr,
  .overrunErr, .txIrq, .rxIrq, .rxDmaAck);

// ---- tb/udp_remote.sv ----
// remote serial peer: sends frames on the receive line, captures transmit frames
module udp_remote (
  input wire logic mclk,
  input wire logic txdPin,
  output logic rxdLine
);
  timeunit 1ns;
  timeprecision 1ns;
  int bitClk = 32; // mclk cycles a bit; raised to act as a slow peer
  initial rxdLine = 1'b1; // idle-high line
  // ======================================
  // drive a frame image, bit 0 first, then release to idle high
  task automatic sendFrame(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      #1 rxdLine = f[i];
      repeat (bitClk - 1) @(posedge mclk);
    end
    @(posedge mclk);
    #1 rxdLine = 1'b1;
  endtask
  // ======================================
  // capture n bits at mid-bit; all ones if no start comes within lim cycles
  task automatic getFrame(input int n, input int lim, output logic [11:0] f);
    int w;
    f = 12'hFFF;
    w = 0;
    while (txdPin !== 1'b0 && w < lim) begin
      @(posedge mclk);
      #1 w++;
    end
    if (w < lim) begin
      for (int i = 0; i < n; i++) begin
        // half a bit first lands every later sample near the centre
        repeat (i == 0 ? bitClk / 2 : bitClk) @(posedge mclk);
        #1 f[i] = txdPin;
      end
    end
  endtask
endmodule // udp_remote

// ---- tb/udp_uart_tb.sv ----
// self-checking bench for the serial port against a remote peer
module udp_uart_tb;
  import udp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ======================================
  // design signals and counters
  logic mclk, sys_rst, rxdPin, twoStop, addrMode, dmaMode, dmaPrioRaise;
  logic txIrqEn, rxIrqEn, errIrqEn, errClear, txWrite, rxRead, txDmaAck, rxDmaAck;
  logic txdPin, txReady, rxValid, txDmaReq, rxDmaReq, parityErr, frameErr, overrunErr;
  logic txIrq, rxIrq, rxLevel;
  logic [15:0] baudDiv;
  logic [1:0] dataBits, parityMode, dmaPrio;
  logic [8:0] txData, txDmaData, rxData;
  int n_fail = 0;
  int samples_checked = 0;
  udp_uart dut (.mclk, .sys_rst, .rxdPin, .txdPin, .baudDiv, .dataBits, .twoStop, .parityMode,
    .addrMode, .dmaMode, .dmaPrioRaise, .txIrqEn, .rxIrqEn, .errIrqEn, .errClear, .txWrite,
    .txData, .txReady, .rxRead, .rxData, .rxValid, .txDmaReq, .txDmaAck, .txDmaData, .rxDmaReq,
    .rxDmaAck, .dmaPrio, .parityErr, .frameErr, .overrunErr, .txIrq, .rxIrq, .rxLevel);
  udp_remote peer (.mclk, .txdPin, .rxdLine(rxdPin));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ======================================
  // compare and closing
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // ======================================
  // frame image: start at bit 0, data lsb first, parity, stops
  function automatic logic [11:0] mkFrame(input logic [8:0] d, output int n);
    int nb;
    logic hasPar;
    nb = addrMode ? 9 : int'(dataBits) + 5;
    hasPar = !addrMode && parityMode != UDP_PAR_NONE;
    mkFrame = 12'hFFF;
    mkFrame[0] = 1'b0;
    for (int i = 0; i < nb; i++) mkFrame[1 + i] = d[i];
    if (hasPar) mkFrame[1 + nb] = ^(d & ~(9'h1FF << nb)) ^ (parityMode == UDP_PAR_ODD);
    n = 2 + nb + int'(hasPar) + int'(twoStop);
  endfunction
  // ======================================
  // programmed transfers
  task automatic sendTx(input logic [8:0] d);
    for (int i = 0; i < 900 && txReady !== 1'b1; i++) tick(1);
    // a wait that runs out is a mismatch of its own
    if (txReady !== 1'b1) n_fail++;
    txWrite = 1'b1;
    txData = d;
    tick(1);
    txWrite = 1'b0;
  endtask
  task automatic readRx(output logic [8:0] d);
    for (int i = 0; i < 900 && rxValid !== 1'b1; i++) tick(1);
    if (rxValid !== 1'b1) n_fail++;
    d = rxData;
    rxRead = 1'b1;
    tick(1);
    rxRead = 1'b0;
  endtask
  // empty the receive path, counting characters
  task automatic drain(output int c);
    logic [8:0] r;
    c = 0;
    for (int k = 0; k < 12; k++) begin
      tick(6);
      if (rxValid === 1'b1) begin
        readRx(r);
        c++;
      end
    end
  endtask
  // ======================================
  // scenarios
  initial begin
    logic [11:0] f, g, fr;
    logic [8:0] d, r, msk;
    int n, m, c;
    {sys_rst, twoStop, addrMode, dmaMode, dmaPrioRaise, txIrqEn, rxIrqEn} = 7'h40;
    {errIrqEn, errClear, txWrite, rxRead, txDmaAck, rxDmaAck} = 6'h00;
    baudDiv = 16'h0002; // 32 clocks a bit, matching the peer
    dataBits = 2'h3;
    parityMode = UDP_PAR_NONE;
    {txData, txDmaData} = 18'h00000;
    tick(20);
    sys_rst = 1'b0;
    tick(1);
    chk("reset", 12'hC01, {txdPin, txReady, rxValid, parityErr, frameErr, overrunErr, txDmaReq,
      rxDmaReq, dmaPrio, rxIrq, rxLevel});
    // every width, parity and stop code, both directions at once
    for (int fm = 0; fm < 8; fm++) begin
      dataBits = fm[1:0];
      parityMode = 2'(fm % 3);
      twoStop = fm[2];
      addrMode = (fm == 7);
      d = 9'h1A5 ^ 9'(fm * 55);
      msk = addrMode ? 9'h1FF : 9'h0FF >> (2'h3 - dataBits);
      f = mkFrame(d, n);
      fr = mkFrame(~d, m);
      fork
        peer.getFrame(n, 2000, g);
        sendTx(d);
        peer.sendFrame(fr, m);
      join
      readRx(r);
      chk("txFrame", f, g);
      chk("rxChar", {3'h0, ~d & msk}, {3'h0, r});
      chk("rxErrs", 12'h000, {parityErr, frameErr, overrunErr});
    end
    // bad parity, then a low stop bit
    {addrMode, twoStop, dataBits, parityMode} = {2'b00, 2'h3, UDP_PAR_EVEN};
    errIrqEn = 1'b1;
    f = mkFrame(9'h03C, n);
    f[9] = ~f[9];
    peer.sendFrame(f, n);
    tick(4);
    chk("parityErr", 12'h005, {parityErr, frameErr, rxIrq});
    f = mkFrame(9'h0C3, n);
    f[10] = 1'b0;
    peer.sendFrame(f, n);
    tick(4);
    chk("frameErr", 12'h001, frameErr);
    errClear = 1'b1;
    tick(1);
    errClear = 1'b0;
    tick(2);
    chk("errClear", 12'h000, {parityErr, frameErr, overrunErr, rxIrq});
    drain(c);
    // queue two back to back; a write while full must vanish
    fork
      begin
        peer.getFrame(n, 2000, f);
        peer.getFrame(n, 2000, g);
        peer.getFrame(n, 500, fr);
      end
      begin
        sendTx(9'h055);
        sendTx(9'h0AA);
        tick(1);
        txWrite = 1'b1;
        txData = 9'h0FF;
        tick(1);
        txWrite = 1'b0;
      end
    join
    chk("txFirst", mkFrame(9'h055, m), f);
    chk("txSecond", mkFrame(9'h0AA, m), g);
    chk("txDropped", 12'hFFF, fr);
    // slow peer overfills the buffers
    peer.bitClk = 33;
    for (int k = 0; k < 10; k++) begin
      f = mkFrame(9'(k), n);
      peer.sendFrame(f, n);
    end
    peer.bitClk = 32;
    tick(4);
    chk("overrun", 12'h001, overrunErr);
    drain(c);
    chk("buffered", 12'(UDP_FIFO_DEPTH + 1), 12'(c));
    errClear = 1'b1;
    tick(1);
    errClear = 1'b0;
    // dma channels and priority
    {dmaMode, dmaPrioRaise} = 2'b11;
    tick(2);
    chk("dmaPrio", 12'h007, {dmaPrio, txDmaReq});
    fr = mkFrame(9'h02D, m);
    fork
      peer.getFrame(n, 2000, g);
      begin
        txDmaAck = 1'b1;
        txDmaData = 9'h0D2;
        tick(1);
        txDmaAck = 1'b0;
      end
      peer.sendFrame(fr, m);
    join
    chk("dmaTx", mkFrame(9'h0D2, m), g);
    for (int i = 0; i < 50 && rxDmaReq !== 1'b1; i++) tick(1);
    chk("dmaRx", 12'h02D, rxData);
    rxDmaAck = 1'b1;
    tick(1);
    rxDmaAck = 1'b0;
    dmaPrioRaise = 1'b0;
    tick(3);
    chk("dmaDone", 12'h000, {rxValid, rxDmaReq, dmaPrio});
    dmaMode = 1'b0;
    txIrqEn = 1'b1;
    tick(2);
    chk("txIrq", 12'h001, txIrq);
    results();
  end
  // hang guard: the scenarios need roughly 9000 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    results();
  end
endmodule // udp_uart_tb
